// file: acr_analog_model.sv
/*
  Model of the oscillator, PLL and failure-detector sources behind the bank.
  Assumes the bench commands ready levels and failure, synchronous to CORE_CLK.
*/
`default_nettype none
module acr_analog_model
  import acr_pkg::*;
(
  // Clock
  input wire logic CORE_CLK,
  // Commands from the bench
  input wire logic [acr_pkg::NUM_STABLE-1:0] READY_CMD,
  input wire logic FAIL_CMD,
  // Toward the bank
  output logic [acr_pkg::NUM_STABLE-1:0] STABLE_READY,
  output logic OSC_FAILURE_DETECTED
);
  timeunit 1ns;
  timeprecision 1ns;
  // Registered so the bank never sees a level change in the edge's own time step
  always_ff @(posedge CORE_CLK) begin
    STABLE_READY <= READY_CMD;
    OSC_FAILURE_DETECTED <= FAIL_CMD;
  end
endmodule
`default_nettype wire

// file: acr_pkg.sv
/*
  Package for the analog control register bank: register byte offsets,
  field positions, reset values and the bus answer for unmapped addresses.
  Assumes a 32-bit Avalon-MM slave with byte addressing.
*/
`default_nettype none
package acr_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_VOLT_DET_EN = 8'h84;
  localparam logic [7:0] OFF_CONV_EN = 8'h8C;
  localparam logic [7:0] OFF_POR_CTRL = 8'h94;
  localparam logic [7:0] OFF_CMP_A_CTRL = 8'h98;
  localparam logic [7:0] OFF_CMP_B_CTRL = 8'h9C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'hA0;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'hA4;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'hA8;
  localparam logic [7:0] OFF_FAIL_DET_EN = 8'hB4;
  localparam logic [31:0] RST_VOLT_DET_EN = 32'h0000_0000;
  localparam logic [31:0] RST_CONV_EN = 32'h0000_001E;
  localparam logic [11:0] RST_POR_CODE = 12'h841;
  localparam logic [11:0] POR_OFF_CODE = 12'h7BE;
  localparam logic [8:0] RST_CMP_CTRL = 9'h000;
  localparam logic [5:0] RST_IRQ_ENABLE = 6'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam int CMP_ON_BIT = 8;
  localparam int NEGATIVE_INPUT_SELECT_HI = 7;
  localparam int NEGATIVE_INPUT_SELECT_LO = 4;
  localparam int PSEL_HI = 3;
  localparam int PSEL_LO = 0;
  localparam int NUM_STABLE = 6;
  localparam int FAIL_BIT = 7;
  localparam int POR_W = 12;
  localparam int CONV_W = 5;
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b01,
    ACR_ANSWER = 2'b10
  } acr_bus_e;
endpackage
`default_nettype wire

// file: acr_regs.sv
/*
  Analog control register bank with clock-source interrupt group.
  Assumes stable/fail inputs are synchronous to CORE_CLK and an Avalon-MM
  master that holds its request until waitrequest is sampled low.
*/
// Design decision made here: the Avalon-MM interface to the registers.
`default_nettype none
module acr_regs
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Avalon-MM slave
  input wire logic [acr_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Analog source status
  input wire logic [acr_pkg::NUM_STABLE-1:0] STABLE_READY,
  input wire logic OSC_FAILURE_DETECTED,
  // Analog controls
  output logic VOLT_DETECTOR_ON,
  output logic CONVERTER_ON,
  output logic POR_ENABLED,
  output logic COMPARATOR_A_ON,
  output logic [3:0] COMPARATOR_A_NEG_SELECT,
  output logic [3:0] COMPARATOR_A_POS_SELECT,
  output logic COMPARATOR_B_ON,
  output logic [3:0] COMPARATOR_B_NEG_SELECT,
  output logic [3:0] COMPARATOR_B_POS_SELECT,
  output logic FAIL_DETECT_ON,
  // Interrupt requests
  output logic IRQ,
  output logic NMI
);
  import acr_pkg::*;

  acr_bus_e state_q;
  logic volt_q;
  logic [CONV_W-1:0] conv_q;
  logic [POR_W-1:0] por_q;
  logic [8:0] cmp_a_q;
  logic [8:0] cmp_b_q;
  logic [NUM_STABLE-1:0] irq_en_q;
  logic [NUM_STABLE-1:0] stable_flag_q;
  logic fail_flag_q;
  logic fail_det_q;
  logic [NUM_STABLE-1:0] ready_prev_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic nmi_q;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] rd_mux;
  logic [NUM_STABLE-1:0] stable_d;
  logic fail_d;

  // Each access takes one wait cycle, so the answer lands on the second edge
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      state_q <= ACR_IDLE;
    end else begin
      case (state_q)
        ACR_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            state_q <= ACR_ANSWER;
          end
        end
        ACR_ANSWER: begin
          state_q <= ACR_IDLE;
        end
        default: begin
          state_q <= ACR_IDLE;
        end
      endcase
    end
  end

  // Waitrequest low only in the answer cycle; high otherwise so a new request stalls
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !(state_q == ACR_IDLE && (AVS_READ || AVS_WRITE));
    end
  end

  assign wr_go = (state_q == ACR_ANSWER) && AVS_WRITE;
  assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                  {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign wval = AVS_WRITEDATA & wmask;

  // Voltage detector enable; only bit 0 is stored, the rest read zero
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      volt_q <= RST_VOLT_DET_EN[0];
    end else if (wr_go && AVS_ADDRESS == OFF_VOLT_DET_EN && AVS_BYTEENABLE[0]) begin
      volt_q <= AVS_WRITEDATA[0];
    end
  end

  // Converter enable; bits 4:1 keep their reset pattern, only bit 0 is writable
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      conv_q <= RST_CONV_EN[CONV_W-1:0];
    end else if (wr_go && AVS_ADDRESS == OFF_CONV_EN && AVS_BYTEENABLE[0]) begin
      conv_q[0] <= AVS_WRITEDATA[0];
    end
  end

  // Byte enables merge so unselected lanes keep their value
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      por_q <= RST_POR_CODE;
    end else if (wr_go && AVS_ADDRESS == OFF_POR_CTRL) begin
      por_q <= (por_q & ~wmask[POR_W-1:0]) | wval[POR_W-1:0];
    end
  end

  // Comparator A; codes above 3 are kept and passed out unchanged
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      cmp_a_q <= RST_CMP_CTRL;
    end else if (wr_go && AVS_ADDRESS == OFF_CMP_A_CTRL) begin
      cmp_a_q <= (cmp_a_q & ~wmask[8:0]) | wval[8:0];
    end
  end

  // Comparator B
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      cmp_b_q <= RST_CMP_CTRL;
    end else if (wr_go && AVS_ADDRESS == OFF_CMP_B_CTRL) begin
      cmp_b_q <= (cmp_b_q & ~wmask[8:0]) | wval[8:0];
    end
  end

  // Interrupt enables
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      irq_en_q <= RST_IRQ_ENABLE;
    end else if (wr_go && AVS_ADDRESS == OFF_IRQ_ENABLE) begin
      irq_en_q <= (irq_en_q & ~wmask[NUM_STABLE-1:0]) | wval[NUM_STABLE-1:0];
    end
  end

  // Failure detection switch
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      fail_det_q <= 1'b0;
    end else if (wr_go && AVS_ADDRESS == OFF_FAIL_DET_EN && AVS_BYTEENABLE[0]) begin
      fail_det_q <= AVS_WRITEDATA[0];
    end
  end

  // Previous ready level, sampled in reset too, so a line that is already high at
  // release is not taken for a rising edge
  always_ff @(posedge CORE_CLK) begin
    ready_prev_q <= STABLE_READY;
  end

  // Sticky flags: a set arriving with a clear wins, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < NUM_STABLE; gi++) begin : g_flag
      always_comb begin
        stable_d[gi] = stable_flag_q[gi];
        if (wr_go && AVS_ADDRESS == OFF_IRQ_CLEAR && wval[gi]) begin
          stable_d[gi] = 1'b0;
        end
        if (STABLE_READY[gi] && !ready_prev_q[gi]) begin
          stable_d[gi] = 1'b1;
        end
      end
    end
  endgenerate

  always_comb begin
    fail_d = fail_flag_q;
    if (wr_go && AVS_ADDRESS == OFF_IRQ_CLEAR && wval[FAIL_BIT]) begin
      fail_d = 1'b0;
    end
    if (OSC_FAILURE_DETECTED && fail_det_q) begin
      fail_d = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      stable_flag_q <= '0;
      fail_flag_q <= 1'b0;
    end else begin
      stable_flag_q <= stable_d;
      fail_flag_q <= fail_d;
    end
  end

  // Requests are registered from the next flag values, so they change on the same edge as the flags
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      irq_q <= 1'b0;
      nmi_q <= 1'b0;
    end else begin
      irq_q <= |(stable_d & irq_en_q);
      nmi_q <= fail_d;
    end
  end

  // Read mux; clear register and unmapped addresses read zero
  always_comb begin
    rd_mux = UNMAPPED_READ;
    case (AVS_ADDRESS)
      OFF_VOLT_DET_EN: rd_mux = {31'h0000_0000, volt_q};
      OFF_CONV_EN: rd_mux = {27'h000_0000, conv_q};
      OFF_POR_CTRL: rd_mux = {20'h0_0000, por_q};
      OFF_CMP_A_CTRL: rd_mux = {23'h00_0000, cmp_a_q};
      OFF_CMP_B_CTRL: rd_mux = {23'h00_0000, cmp_b_q};
      OFF_IRQ_STATUS: rd_mux = {24'h00_0000, fail_flag_q, 1'b0, stable_flag_q};
      OFF_IRQ_ENABLE: rd_mux = {26'h000_0000, irq_en_q};
      OFF_FAIL_DET_EN: rd_mux = {31'h0000_0000, fail_det_q};
      default: rd_mux = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      rdata_q <= '0;
    end else if (state_q == ACR_IDLE && AVS_READ) begin
      rdata_q <= rd_mux;
    end
  end

  // Registered control outputs
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      VOLT_DETECTOR_ON <= 1'b0;
      CONVERTER_ON <= 1'b0;
      POR_ENABLED <= 1'b1;
      COMPARATOR_A_ON <= 1'b0;
      COMPARATOR_A_NEG_SELECT <= 4'h0;
      COMPARATOR_A_POS_SELECT <= 4'h0;
      COMPARATOR_B_ON <= 1'b0;
      COMPARATOR_B_NEG_SELECT <= 4'h0;
      COMPARATOR_B_POS_SELECT <= 4'h0;
      FAIL_DETECT_ON <= 1'b0;
    end else begin
      VOLT_DETECTOR_ON <= volt_q;
      CONVERTER_ON <= conv_q[0];
      POR_ENABLED <= (por_q != POR_OFF_CODE);
      COMPARATOR_A_ON <= cmp_a_q[CMP_ON_BIT];
      COMPARATOR_A_NEG_SELECT <= cmp_a_q[NEGATIVE_INPUT_SELECT_HI:NEGATIVE_INPUT_SELECT_LO];
      COMPARATOR_A_POS_SELECT <= cmp_a_q[PSEL_HI:PSEL_LO];
      COMPARATOR_B_ON <= cmp_b_q[CMP_ON_BIT];
      COMPARATOR_B_NEG_SELECT <= cmp_b_q[NEGATIVE_INPUT_SELECT_HI:NEGATIVE_INPUT_SELECT_LO];
      COMPARATOR_B_POS_SELECT <= cmp_b_q[PSEL_HI:PSEL_LO];
      FAIL_DETECT_ON <= fail_det_q;
    end
  end

  assign AVS_READDATA = rdata_q;
  assign IRQ = irq_q;
  assign NMI = nmi_q;

  // Assertions
  a_por_code_off: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (por_q == POR_OFF_CODE) |=> !POR_ENABLED)
    else $error("por enabled with off code");
  a_por_code_on: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (por_q != POR_OFF_CODE) |=> POR_ENABLED)
    else $error("por disabled with other code");
  a_por_write: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_go && AVS_ADDRESS == OFF_POR_CTRL && AVS_BYTEENABLE == 4'hF) |=>
    por_q == $past(AVS_WRITEDATA[POR_W-1:0]))
    else $error("por code write lost");
  a_volt_follow: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    ##1 VOLT_DETECTOR_ON == $past(volt_q))
    else $error("voltage detector on mismatch");
  a_volt_write: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_go && AVS_ADDRESS == OFF_VOLT_DET_EN && AVS_BYTEENABLE[0]) |=>
    volt_q == $past(AVS_WRITEDATA[0]))
    else $error("voltage detector write lost");
  a_conv_follow: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    ##1 CONVERTER_ON == $past(conv_q[0]))
    else $error("converter on mismatch");
  a_conv_write: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_go && AVS_ADDRESS == OFF_CONV_EN && AVS_BYTEENABLE[0]) |=>
    conv_q == {RST_CONV_EN[CONV_W-1:1], $past(AVS_WRITEDATA[0])})
    else $error("converter write wrong");
  a_cmp_a_sel: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $changed(cmp_a_q) |=> COMPARATOR_A_ON == $past(cmp_a_q[8]) &&
    COMPARATOR_A_NEG_SELECT == $past(cmp_a_q[7:4]))
    else $error("comparator a outputs wrong");
  a_cmp_a_pos: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $changed(cmp_a_q) |=> COMPARATOR_A_POS_SELECT == $past(cmp_a_q[3:0]))
    else $error("comparator a positive select wrong");
  a_cmp_b_on: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $changed(cmp_b_q) |=> COMPARATOR_B_ON == $past(cmp_b_q[8]) &&
    COMPARATOR_B_NEG_SELECT == $past(cmp_b_q[7:4]))
    else $error("comparator b outputs wrong");
  a_cmp_b_sel: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $changed(cmp_b_q) |=> COMPARATOR_B_POS_SELECT == $past(cmp_b_q[3:0]))
    else $error("comparator b select wrong");
  a_status_read: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (state_q == ACR_IDLE && AVS_READ && AVS_ADDRESS == OFF_IRQ_STATUS) |=>
    AVS_READDATA[7:0] == {$past(fail_flag_q), 1'b0, $past(stable_flag_q)} &&
    AVS_READDATA[31:8] == 24'h00_0000)
    else $error("status read wrong");
  a_irq_en_write: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_go && AVS_ADDRESS == OFF_IRQ_ENABLE && AVS_BYTEENABLE[0]) |=>
    irq_en_q == $past(AVS_WRITEDATA[NUM_STABLE-1:0]))
    else $error("enable write lost");
  a_flag_sets: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $rose(STABLE_READY[0]) |=> stable_flag_q[0])
    else $error("stable flag missed rise");
  a_zero_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_go && AVS_ADDRESS == OFF_IRQ_CLEAR && !wval[0] && stable_flag_q[0]) |=>
    stable_flag_q[0])
    else $error("zero clear bit dropped a flag");
  a_flag_sticks: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    stable_flag_q[1] && !(wr_go && AVS_ADDRESS == OFF_IRQ_CLEAR) |=> stable_flag_q[1])
    else $error("stable flag dropped without clear");
  a_clear_works: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_go && AVS_ADDRESS == OFF_IRQ_CLEAR && AVS_BYTEENABLE[0] && AVS_WRITEDATA[1] &&
    !(STABLE_READY[1] && !ready_prev_q[1])) |=> !stable_flag_q[1])
    else $error("stable flag not cleared");
  a_fail_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_go && AVS_ADDRESS == OFF_IRQ_CLEAR && AVS_BYTEENABLE[0] &&
    AVS_WRITEDATA[FAIL_BIT] && !(OSC_FAILURE_DETECTED && fail_det_q)) |=> !fail_flag_q)
    else $error("failure flag not cleared");
  a_fail_gated: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !fail_flag_q && !fail_det_q |=> !fail_flag_q)
    else $error("failure flag set while detection off");
  a_fail_sets: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (OSC_FAILURE_DETECTED && fail_det_q) |=> fail_flag_q)
    else $error("failure flag missed event");
  a_nmi_follow: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    fail_flag_q |-> ##[0:1] NMI)
    else $error("nmi not raised");
  a_nmi_only_flag: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    NMI == fail_flag_q)
    else $error("nmi differs from failure flag");
  a_irq_mask: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    IRQ |-> $past(|(stable_d & irq_en_q)))
    else $error("irq without enabled flag");
  a_irq_raise: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (|(stable_d & irq_en_q)) |=> IRQ)
    else $error("irq missing for enabled flag");
  a_bus_answer: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (state_q == ACR_IDLE && AVS_READ) |=> !AVS_WAITREQUEST)
    else $error("no answer after one wait cycle");
  c_irq: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(IRQ));
  c_nmi: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(NMI));
  c_clear: cover property (@(posedge CORE_CLK) disable iff (!NRST)
    stable_flag_q[0] ##1 !stable_flag_q[0]);
  c_por_off: cover property (@(posedge CORE_CLK) disable iff (!NRST) $fell(POR_ENABLED));
  c_cmp_b_on: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(COMPARATOR_B_ON));
endmodule
`default_nettype wire

// file: acr_regs_bench.sv
/*
  Self-checking bench for the analog control register bank.
  Assumes acr_pkg and the source model; all bus access via Avalon-MM tasks.
*/
`default_nettype none
module acr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import acr_pkg::*;
  logic clk, nrst, rd, wr, wreq, fail, fail_cmd, irq, nmi;
  logic vd_on, cv_on, por_on, a_on, b_on, fd_on;
  logic [3:0] a_n, a_p, b_n, b_p, be, be_sel;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [5:0] ready, ready_cmd;
  int err_total, n_compared;

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  acr_regs u_acr_regs (.CORE_CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .STABLE_READY(ready), .OSC_FAILURE_DETECTED(fail),
    .VOLT_DETECTOR_ON(vd_on), .CONVERTER_ON(cv_on), .POR_ENABLED(por_on),
    .COMPARATOR_A_ON(a_on), .COMPARATOR_A_NEG_SELECT(a_n), .COMPARATOR_A_POS_SELECT(a_p),
    .COMPARATOR_B_ON(b_on), .COMPARATOR_B_NEG_SELECT(b_n), .COMPARATOR_B_POS_SELECT(b_p),
    .FAIL_DETECT_ON(fd_on), .IRQ(irq), .NMI(nmi));
  acr_analog_model u_acr_analog_model (.CORE_CLK(clk), .READY_CMD(ready_cmd),
    .FAIL_CMD(fail_cmd), .STABLE_READY(ready), .OSC_FAILURE_DETECTED(fail));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until the rising edge at which waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= be_sel;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_total++;
      $display("MISMATCH t=%0t bus answer missing", $time);
      stop_test();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  // Controls and flags settle within a fixed registered latency
  task settle();
    repeat (3) @(negedge clk);
  endtask

  task src(input logic [5:0] r, input logic f);
    @(posedge clk);
    ready_cmd <= r;
    fail_cmd <= f;
    settle();
  endtask

  task t_reset();
    rd_chk(OFF_VOLT_DET_EN, 32'h0);
    rd_chk(OFF_CONV_EN, 32'h0000_001E);
    rd_chk(OFF_POR_CTRL, 32'h0000_0841);
    rd_chk(OFF_CMP_A_CTRL, 32'h0);
    rd_chk(OFF_CMP_B_CTRL, 32'h0);
    rd_chk(OFF_IRQ_ENABLE, 32'h0);
    rd_chk(OFF_IRQ_STATUS, 32'h0);
    rd_chk(8'hF0, UNMAPPED_READ);
    check(por_on, 1'b1);
    $display("test reset values done");
  endtask

  task t_controls();
    int i;
    logic [31:0] v;
    wr32(OFF_VOLT_DET_EN, 32'hFFFF_FFFF);
    rd_chk(OFF_VOLT_DET_EN, 32'h1);
    wr32(OFF_CONV_EN, 32'h1);
    rd_chk(OFF_CONV_EN, 32'h0000_001F);
    wr32(OFF_POR_CTRL, 32'hFFFF_F7BE);
    rd_chk(OFF_POR_CTRL, 32'h0000_07BE);
    settle();
    check({vd_on, cv_on, por_on}, 3'b110);
    wr32(OFF_POR_CTRL, 32'h7BF);
    settle();
    check(por_on, 1'b1);
    be_sel = 4'h1;
    wr32(OFF_POR_CTRL, 32'h0000_0000);
    be_sel = 4'hF;
    rd_chk(OFF_POR_CTRL, 32'h0000_0700);
    for (i = 0; i < 4; i++) begin
      v = {23'h0, i[0], 4'(i), 4'(3 - i)};
      wr32(OFF_CMP_A_CTRL, v | 32'hFFFF_FE00);
      wr32(OFF_CMP_B_CTRL, v ^ 32'h133);
      settle();
      check({a_on, a_n, a_p}, v[8:0]);
      check({b_on, b_n, b_p}, v[8:0] ^ 9'h133);
      rd_chk(OFF_CMP_A_CTRL, v);
    end
    $display("test controls done");
  endtask

  task t_irq();
    int i;
    wr32(OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
    rd_chk(OFF_IRQ_ENABLE, 32'h3F);
    for (i = 0; i < 6; i++) begin
      src(6'(1 << i), 1'b0);
      src(6'h0, 1'b0);
      check(irq, 1'b1);
      wr32(OFF_IRQ_CLEAR, 32'h0);
      wr32(OFF_IRQ_STATUS, 32'hFFFF_FFFF);
      rd_chk(OFF_IRQ_STATUS, 32'(1 << i));
      wr32(OFF_IRQ_CLEAR, 32'(1 << i));
      rd_chk(OFF_IRQ_STATUS, 32'h0);
      settle();
      check(irq, 1'b0);
    end
    wr32(OFF_IRQ_ENABLE, 32'h3E);
    src(6'h1, 1'b0);
    check(irq, 1'b0);
    wr32(OFF_IRQ_ENABLE, 32'h1);
    settle();
    check(irq, 1'b1);
    src(6'h0, 1'b0);
    wr32(OFF_IRQ_CLEAR, 32'h1);
    $display("test interrupts done");
  endtask

  task t_fail();
    src(6'h0, 1'b1);
    rd_chk(OFF_IRQ_STATUS, 32'h0);
    check(nmi, 1'b0);
    wr32(OFF_IRQ_ENABLE, 32'h0);
    wr32(OFF_FAIL_DET_EN, 32'h1);
    settle();
    check({fd_on, nmi, irq}, 3'b110);
    src(6'h0, 1'b0);
    rd_chk(OFF_IRQ_STATUS, 32'h80);
    wr32(OFF_IRQ_CLEAR, 32'h80);
    rd_chk(OFF_IRQ_STATUS, 32'h0);
    settle();
    check(nmi, 1'b0);
    $display("test failure flag done");
  endtask

  task stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    stop_test();
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    {nrst, rd, wr, fail_cmd} = 4'b0;
    addr = 8'h0;
    wdata = 32'h0;
    be = 4'hF;
    be_sel = 4'hF;
    ready_cmd = 6'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_controls();
    t_irq();
    t_fail();
    stop_test();
  end
endmodule
`default_nettype wire
